// file: flash_id_pkg.sv
package flash_id_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W    = 16;
    localparam int IB_ADDR_W = 24;
    localparam int PB_ADDR_W = 16;
    localparam int ES_ADDR_W = 16;
    localparam int NUM_FLASH = 16;
    localparam int BE_W      = 2;

    // ------------------------------------------------------------------
    // Flash control registers on the internal memory bus
    // ------------------------------------------------------------------
    // Index order: control0 low/high, control1 low/high, data0 low/high,
    // data1 low/high, address low/high, error, nv write protect low/high,
    // nv access protect0, nv access protect1 low/high
    localparam int IDX_CTRL0_LOW  = 0;
    localparam int IDX_DATA0_LOW  = 4;
    localparam int IDX_ADDR_LOW   = 8;
    localparam int IDX_ERROR      = 10;
    localparam int IDX_NV_FIRST   = 11;

    localparam logic [NUM_FLASH-1:0][IB_ADDR_W-1:0] FLASH_ADDR = {
        24'h0e_dfbe, 24'h0e_dfbc, 24'h0e_dfb8, 24'h0e_dfb6,
        24'h0e_dfb4, 24'h0e_0014, 24'h0e_0012, 24'h0e_0010,
        24'h0e_000e, 24'h0e_000c, 24'h0e_000a, 24'h0e_0008,
        24'h0e_0006, 24'h0e_0004, 24'h0e_0002, 24'h0e_0000
    };

    localparam logic [NUM_FLASH-1:0][DATA_W-1:0] FLASH_RESET = {
        16'hffff, 16'hffff, 16'hacff, 16'hffff,
        16'hffff, 16'h0000, 16'h0000, 16'h0000,
        16'hffff, 16'hffff, 16'hffff, 16'hffff,
        16'h0000, 16'h0000, 16'h0000, 16'h0000
    };

    // Flash register window, used to flag misses inside it
    localparam logic [7:0] FLASH_WINDOW = 8'h0e;
    localparam int         WINDOW_LSB   = 16;

    // Only both byte lanes together make a legal access
    localparam logic [BE_W-1:0] BYTE_EN_WORD = 2'h3;

    // ------------------------------------------------------------------
    // Volatile temporary unprotection register, peripheral bus
    // ------------------------------------------------------------------
    localparam logic [PB_ADDR_W-1:0] UNPROT_ADDR  = 16'hee90;
    localparam logic [DATA_W-1:0]    UNPROT_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Identification registers in extended function register space
    // ------------------------------------------------------------------
    localparam logic [ES_ADDR_W-1:0] ID_PROG_ADDR  = 16'hf078;
    localparam logic [ES_ADDR_W-1:0] ID_MEM_ADDR   = 16'hf07a;
    localparam logic [ES_ADDR_W-1:0] ID_PART_ADDR  = 16'hf07c;
    localparam logic [ES_ADDR_W-1:0] ID_MAKER_ADDR = 16'hf07e;

    localparam logic [4:0] MAKER_FIXED      = 5'h03;
    localparam logic [3:0] MEM_KIND_NONE    = 4'h0;
    localparam logic [3:0] MEM_KIND_MASKROM = 4'h1;
    localparam logic [3:0] MEM_KIND_STDFL   = 4'h2;
    localparam logic [3:0] MEM_KIND_HPFL    = 4'h3;
    localparam logic [3:0] MEM_KIND_UNINIT  = 4'hf;
    localparam logic [7:0] PROG_VDD_5V      = 8'h40;
    localparam logic [7:0] PROG_VPP_NONE    = 8'h00;

    // ------------------------------------------------------------------
    // Boot select capture
    // ------------------------------------------------------------------
    localparam logic [1:0] BOOT_SETTLE_CYCLES = 2'h3;

endpackage

// file: id_if.sv
interface id_if;
    logic [15:0] addr;
    logic        idValid;
    logic [15:0] data;
    logic        hit;

    modport mux (
        input  addr,
        input  idValid,
        output data,
        output hit
    );

    modport host (
        output addr,
        output idValid,
        input  data,
        input  hit
    );
endinterface

// file: boot_pin_sync.sv
module boot_pin_sync (
    // Clock and reset
    input  logic mclk,
    input  logic rstn,
    input  logic ce,
    // Pin and settled level
    input  logic pinIn,
    output logic level
);
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic stable;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    // Level only moves once the second and third stage agree
    always_comb begin
        s_d        = s_q;
        s_d.ff1    = pinIn;
        s_d.ff2    = s_q.ff1;
        s_d.ff3    = s_q.ff2;
        if (s_q.ff2 == s_q.ff3) begin
            s_d.stable = s_q.ff3;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign level = s_q.stable;
endmodule

// file: id_reg_mux.sv
module id_reg_mux
    import flash_id_pkg::*;
#(
    parameter logic [10:0] MAKER_CODE    = 11'h2aa,
    parameter logic [11:0] PART_CODE     = 12'h5a5,
    parameter logic [3:0]  REVISION      = 4'h1,
    parameter logic [11:0] MEM_CAPACITY  = 12'h080
) (
    // Lookup port
    id_if.mux idx
);
    logic [3:0] memKind;

    // Kind nibble reads all ones until the flash has initialised
    assign memKind = idx.idValid ? MEM_KIND_HPFL
                                 : MEM_KIND_UNINIT;

    always_comb begin
        idx.hit  = 1'b1;
        idx.data = '0;
        unique case (idx.addr)
            ID_MAKER_ADDR: idx.data = {MAKER_CODE, MAKER_FIXED};
            ID_PART_ADDR:  idx.data = {PART_CODE, REVISION};
            ID_MEM_ADDR:   idx.data = {memKind, MEM_CAPACITY};
            ID_PROG_ADDR:  idx.data = {PROG_VPP_NONE,
                                       PROG_VDD_5V};
            default: begin
                idx.hit  = 1'b0;
                idx.data = '0;
            end
        endcase
    end
endmodule

// file: flash_id_regs.sv
module flash_id_regs
#(
    parameter logic [10:0] MAKER_CODE   = 11'h2aa,
    parameter logic [11:0] PART_CODE    = 12'h5a5,
    parameter logic [3:0]  REVISION     = 4'h1,
    parameter logic [11:0] MEM_CAPACITY = 12'h080
) (
    // Clock, reset and clock enable
    input  logic                                 mclk,
    input  logic                                 rstn,
    input  logic                                 ce,
    // Boot selection and flash controller status
    input  logic                                 bootSelectPin,
    input  logic                                 flashInitDone,
    input  logic [flash_id_pkg::DATA_W-1:0]      errorSet,
    output logic                                 fetchEnable,
    output logic                                 bootInternal,
    output logic                                 idValid,
    // Internal memory bus
    input  logic                                 ibSel,
    input  logic                                 ibWr,
    input  logic                                 ibBitOp,
    input  logic [flash_id_pkg::BE_W-1:0]        ibByteEn,
    input  logic [flash_id_pkg::IB_ADDR_W-1:0]   ibAddr,
    input  logic [flash_id_pkg::DATA_W-1:0]      ibWdata,
    output logic [flash_id_pkg::DATA_W-1:0]      ibRdata,
    output logic                                 ibAck,
    output logic                                 ibErr,
    // On-chip peripheral bus
    input  logic                                 pbSel,
    input  logic                                 pbWr,
    input  logic [flash_id_pkg::PB_ADDR_W-1:0]   pbAddr,
    input  logic [flash_id_pkg::DATA_W-1:0]      pbWdata,
    output logic [flash_id_pkg::DATA_W-1:0]      pbRdata,
    output logic                                 pbAck,
    // Extended function register space
    input  logic                                 esSel,
    input  logic                                 esWr,
    input  logic [flash_id_pkg::ES_ADDR_W-1:0]   esAddr,
    output logic [flash_id_pkg::DATA_W-1:0]      esRdata,
    output logic                                 esAck,
    // Register contents toward the flash controller
    output logic [4*flash_id_pkg::DATA_W-1:0]    ctrlWords,
    output logic [4*flash_id_pkg::DATA_W-1:0]    dataWords,
    output logic [2*flash_id_pkg::DATA_W-1:0]    addrWords,
    output logic [flash_id_pkg::DATA_W-1:0]      errorWord,
    output logic [5*flash_id_pkg::DATA_W-1:0]    protWords,
    output logic [flash_id_pkg::DATA_W-1:0]      unprotectWord
);
    import flash_id_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef logic [NUM_FLASH-1:0][DATA_W-1:0] flash_bank_t;

    typedef struct packed {
        flash_bank_t       flash;
        logic [DATA_W-1:0] unprot;
        logic [DATA_W-1:0] ibRdata;
        logic              ibAck;
        logic              ibErr;
        logic [DATA_W-1:0] pbRdata;
        logic              pbAck;
        logic [DATA_W-1:0] esRdata;
        logic              esAck;
        logic              idValid;
        logic [1:0]        settle;
        logic              bootCaught;
        logic              bootInternal;
    } state_t;

    localparam state_t STATE_RESET = '{
        flash:        FLASH_RESET,
        unprot:       UNPROT_RESET,
        ibRdata:      '0,
        ibAck:        1'b0,
        ibErr:        1'b0,
        pbRdata:      '0,
        pbAck:        1'b0,
        esRdata:      '0,
        esAck:        1'b0,
        idValid:      1'b0,
        settle:       '0,
        bootCaught:   1'b0,
        bootInternal: 1'b0
    };

    state_t s_q;
    state_t s_d;

    // ------------------------------------------------------------------
    // Boot select pin
    // ------------------------------------------------------------------
    logic bootLevel;

    // Synchroniser keeps sampling through reset, so the level of the
    // pin held during reset is already settled when reset releases
    boot_pin_sync bootSync (
        .mclk  (mclk),
        .rstn  (1'b1),
        .ce    (ce),
        .pinIn (bootSelectPin),
        .level (bootLevel)
    );

    // ------------------------------------------------------------------
    // Identification lookup
    // ------------------------------------------------------------------
    id_if idBus ();

    assign idBus.addr    = esAddr;
    assign idBus.idValid = s_q.idValid;

    id_reg_mux #(
        .MAKER_CODE   (MAKER_CODE),
        .PART_CODE    (PART_CODE),
        .REVISION     (REVISION),
        .MEM_CAPACITY (MEM_CAPACITY)
    ) idMux (
        .idx (idBus)
    );

    // ------------------------------------------------------------------
    // Internal memory bus decode
    // ------------------------------------------------------------------
    logic [NUM_FLASH-1:0]              ibHit;
    logic [NUM_FLASH-1:0][DATA_W-1:0]  ibMasked;
    logic [DATA_W-1:0]                 ibReadMux;
    logic                              ibInWindow;
    logic                              ibWholeWord;

    // One comparator and one read gate per flash register
    for (genvar i = 0; i < NUM_FLASH; i++) begin : gEntry
        assign ibHit[i]    = (ibAddr == FLASH_ADDR[i]);
        assign ibMasked[i] = ibHit[i] ? s_q.flash[i] : '0;
    end

    always_comb begin
        ibReadMux = '0;
        for (int k = 0; k < NUM_FLASH; k++) begin
            ibReadMux = ibReadMux | ibMasked[k];
        end
    end

    assign ibInWindow  = (ibAddr[IB_ADDR_W-1:WINDOW_LSB] == FLASH_WINDOW);
    // Partial lanes and set, clear or test operations are not taken
    assign ibWholeWord = (ibByteEn == BYTE_EN_WORD) && !ibBitOp;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.ibAck = 1'b0;
        s_d.ibErr = 1'b0;
        s_d.pbAck = 1'b0;
        s_d.esAck = 1'b0;

        // Boot select is caught once, after the synchroniser has settled
        if (!s_q.bootCaught) begin
            if (s_q.settle == BOOT_SETTLE_CYCLES) begin
                s_d.bootCaught   = 1'b1;
                s_d.bootInternal = bootLevel;
            end else begin
                s_d.settle = s_q.settle + 2'h1;
            end
        end

        // Initialisation done is sticky until the next reset
        if (flashInitDone) begin
            s_d.idValid = 1'b1;
        end

        // Flash registers: whole words only, misses in window flagged
        if (ibSel && ibInWindow) begin
            s_d.ibAck = 1'b1;
            if ((ibHit == '0) || !ibWholeWord) begin
                s_d.ibErr   = 1'b1;
                s_d.ibRdata = '0;
            end else if (ibWr) begin
                for (int k = 0; k < NUM_FLASH; k++) begin
                    if (ibHit[k]) begin
                        s_d.flash[k] = ibWdata;
                    end
                end
            end else begin
                s_d.ibRdata = ibReadMux;
            end
        end

        // Controller error events win over a software write
        s_d.flash[IDX_ERROR] = s_d.flash[IDX_ERROR] | errorSet;

        // Volatile unprotection register sits on the peripheral bus
        if (pbSel && (pbAddr == UNPROT_ADDR)) begin
            s_d.pbAck = 1'b1;
            if (pbWr) begin
                s_d.unprot = pbWdata;
            end else begin
                s_d.pbRdata = s_q.unprot;
            end
        end

        // Identification registers: reads answered, writes dropped
        if (esSel && idBus.hit) begin
            s_d.esAck = 1'b1;
            if (!esWr) begin
                s_d.esRdata = idBus.data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= STATE_RESET;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Internal boot holds fetches until the identification data is good;
    // external boot runs at once and software polls the kind nibble
    assign fetchEnable  = s_q.bootCaught &&
                          (!s_q.bootInternal || s_q.idValid);
    assign bootInternal = s_q.bootInternal;
    assign idValid      = s_q.idValid;

    assign ibRdata = s_q.ibRdata;
    assign ibAck   = s_q.ibAck;
    assign ibErr   = s_q.ibErr;
    assign pbRdata = s_q.pbRdata;
    assign pbAck   = s_q.pbAck;
    assign esRdata = s_q.esRdata;
    assign esAck   = s_q.esAck;

    assign ctrlWords     = s_q.flash[IDX_CTRL0_LOW+3:IDX_CTRL0_LOW];
    assign dataWords     = s_q.flash[IDX_DATA0_LOW+3:IDX_DATA0_LOW];
    assign addrWords     = s_q.flash[IDX_ADDR_LOW+1:IDX_ADDR_LOW];
    assign errorWord     = s_q.flash[IDX_ERROR];
    assign protWords     = s_q.flash[NUM_FLASH-1:IDX_NV_FIRST];
    assign unprotectWord = s_q.unprot;
endmodule

// file: flash_id_regs_checker.sv
module flash_id_regs_checker
    import flash_id_pkg::*;
(
    // Clock and reset
    input logic                               mclk,
    input logic                               rstn,
    input logic                               ce,
    // Status
    input logic                               flashInitDone,
    input logic                               idValid,
    input logic                               bootInternal,
    input logic                               fetchEnable,
    // Buses
    input logic                               ibSel,
    input logic                               ibBitOp,
    input logic [flash_id_pkg::BE_W-1:0]      ibByteEn,
    input logic [flash_id_pkg::IB_ADDR_W-1:0] ibAddr,
    input logic                               ibAck,
    input logic                               ibErr,
    input logic                               pbSel,
    input logic [flash_id_pkg::PB_ADDR_W-1:0] pbAddr,
    input logic                               pbAck,
    input logic                               esSel,
    input logic                               esWr,
    input logic [flash_id_pkg::ES_ADDR_W-1:0] esAddr,
    input logic                               esAck,
    input logic [flash_id_pkg::DATA_W-1:0]    esRdata
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic ibTake;
    logic esRead;
    assign ibTake = ce && ibSel && ibAddr[23:16] == 8'h0e;
    assign esRead = ce && esSel && !esWr;

    chk_ib_ack: assert property (ibTake |=> ibAck)
        else $error("memory bus request not acknowledged");
    chk_ib_silent: assert property (ce && !ibTake |=> !ibAck && !ibErr)
        else $error("memory bus answer without request");
    chk_ib_refuse: assert property (ibTake && (ibBitOp || ibByteEn != 2'h3)
        |=> ibAck && ibErr)
        else $error("partial or bit access not refused");
    chk_pb_ack: assert property (ce && pbSel && pbAddr == UNPROT_ADDR
        |=> pbAck)
        else $error("peripheral bus request not acknowledged");
    chk_es_ack: assert property (ce && esSel && esAddr[15:3] == 13'h1e0f
        && !esAddr[0] |=> esAck)
        else $error("identification access not acknowledged");
    chk_prog_fixed: assert property (esRead && esAddr == ID_PROG_ADDR
        |=> esRdata == 16'h0040)
        else $error("programming word wrong");
    chk_kind_blank: assert property (esRead && esAddr == ID_MEM_ADDR
        && !idValid |=> esRdata[15:12] == 4'hf)
        else $error("memory kind not blank before init");
    chk_kind_ready: assert property (esRead && esAddr == ID_MEM_ADDR
        && idValid |=> esRdata[15:12] == 4'h3)
        else $error("memory kind wrong after init");
    chk_maker_low: assert property (esRead && esAddr == ID_MAKER_ADDR
        |=> esRdata[4:0] == 5'h03)
        else $error("maker low bits wrong");
    chk_valid_sticky: assert property (ce && (flashInitDone || idValid)
        |=> idValid)
        else $error("identification valid flag not set");
    chk_fetch_wait: assert property (bootInternal && !idValid
        |-> !fetchEnable)
        else $error("internal fetch before init done");

    cover property (ibAck && ibErr);
    cover property (esAck && idValid);
    cover property (bootInternal && fetchEnable);
endmodule

bind flash_id_regs flash_id_regs_checker i_flash_id_regs_checker (
    .mclk, .rstn, .ce, .flashInitDone, .idValid, .bootInternal,
    .fetchEnable, .ibSel, .ibBitOp, .ibByteEn, .ibAddr, .ibAck, .ibErr,
    .pbSel, .pbAddr, .pbAck, .esSel, .esWr, .esAddr, .esAck, .esRdata
);

// file: test_flash_id_regs.sv
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end

module test_flash_id_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_id_pkg::*;

    logic        mclk, rstn, ce, bootSelectPin, flashInitDone;
    logic        fetchEnable, bootInternal, idValid;
    logic        ibSel, ibWr, ibBitOp, ibAck, ibErr;
    logic [1:0]  ibByteEn;
    logic [23:0] ibAddr;
    logic [15:0] ibWdata, ibRdata, errorSet, errorWord, unprotectWord;
    logic        pbSel, pbWr, pbAck, esSel, esWr, esAck;
    logic [15:0] pbAddr, pbWdata, pbRdata, esAddr, esRdata;
    logic [63:0] ctrlWords, dataWords;
    logic [31:0] addrWords;
    logic [79:0] protWords;
    int          checks = 0;
    int          failures = 0;

    // Identity values are arbitrary
    flash_id_regs #(.MAKER_CODE(11'h155), .PART_CODE(12'h3c3),
        .REVISION(4'h2), .MEM_CAPACITY(12'h080)) i_flash_id_regs (
        .mclk, .rstn, .ce, .bootSelectPin, .flashInitDone, .errorSet,
        .fetchEnable, .bootInternal, .idValid, .ibSel, .ibWr, .ibBitOp,
        .ibByteEn, .ibAddr, .ibWdata, .ibRdata, .ibAck, .ibErr, .pbSel,
        .pbWr, .pbAddr, .pbWdata, .pbRdata, .pbAck, .esSel, .esWr, .esAddr,
        .esRdata, .esAck, .ctrlWords, .dataWords, .addrWords, .errorWord,
        .protWords, .unprotectWord);

    // ----------------------------------------
    // Bus tasks, reset and helpers
    // ----------------------------------------
    function automatic logic [23:0] fa(int i);
        logic [15:0] nv [5] = '{16'hdfb4, 16'hdfb6, 16'hdfb8, 16'hdfbc,
                                16'hdfbe};
        return i < 11 ? 24'h0e_0000 + 24'(2 * i) : {8'h0e, nv[i - 11]};
    endfunction

    function automatic logic [15:0] fr(int i);
        if (i == 13) return 16'hacff;
        return (i inside {[4:7], 11, 12, 14, 15}) ? 16'hffff : 16'h0000;
    endfunction

    task automatic ib(input logic w, b, input logic [1:0] be,
                      input logic [23:0] a, input logic [15:0] d);
        @(posedge mclk);
        ibSel <= 1'b1;
        ibWr <= w;
        ibBitOp <= b;
        ibByteEn <= be;
        ibAddr <= a;
        ibWdata <= d;
        @(posedge mclk);
        ibSel <= 1'b0;
        #1;
    endtask

    task automatic pb(input logic w, input logic [15:0] a, d);
        @(posedge mclk);
        pbSel <= 1'b1;
        pbWr <= w;
        pbAddr <= a;
        pbWdata <= d;
        @(posedge mclk);
        pbSel <= 1'b0;
        #1;
    endtask

    task automatic es(input logic w, input logic [15:0] a);
        @(posedge mclk);
        esSel <= 1'b1;
        esWr <= w;
        esAddr <= a;
        @(posedge mclk);
        esSel <= 1'b0;
        #1;
    endtask

    task automatic rst(input logic pin, input int n);
        @(posedge mclk);
        rstn <= 1'b0;
        bootSelectPin <= pin;
        flashInitDone <= 1'b0;
        repeat (n) @(posedge mclk);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        repeat (2000) @(posedge mclk);
        failures++;
        close_out();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {rstn, ce, bootSelectPin, flashInitDone} = 4'b0100;
        {ibSel, ibWr, ibBitOp, ibByteEn, ibAddr, ibWdata} = '0;
        {pbSel, pbWr, pbAddr, pbWdata, esSel, esWr, esAddr} = '0;
        errorSet = 16'h0000;
        rst(1'b0, 3);
        `CHK("data", {4{16'hffff}}, dataWords)
        `CHK("ctrl", 64'h0, ctrlWords)
        `CHK("addr", 32'h0, addrWords)
        `CHK("prot", 80'hffff_ffff_acff_ffff_ffff, protWords)
        for (int i = 0; i < 16; i++) begin
            ib(1'b0, 1'b0, 2'h3, fa(i), 16'h0000);
            `CHK("reset read", fr(i), ibRdata)
        end
        for (int i = 0; i < 16; i++)
            ib(1'b1, 1'b0, 2'h3, fa(i), 16'h0a50 + 16'(i));
        for (int i = 0; i < 16; i++) begin
            ib(1'b0, 1'b0, 2'h3, fa(i), 16'h0000);
            `CHK("readback", 16'h0a50 + 16'(i), ibRdata)
            `CHK("read ack", 1'b1, ibAck)
        end
        ib(1'b1, 1'b0, 2'h1, fa(0), 16'hbeef);
        `CHK("byte refused", 1'b1, ibErr)
        ib(1'b1, 1'b1, 2'h3, fa(0), 16'hbeef);
        `CHK("bit refused", 1'b1, ibErr)
        `CHK("ctrl kept", 16'h0a50, ctrlWords[15:0])
        ib(1'b0, 1'b1, 2'h3, fa(0), 16'h0000);
        `CHK("bit read", 16'h0000, ibRdata)
        ib(1'b0, 1'b0, 2'h3, 24'h0f_0000, 16'h0000);
        `CHK("outside", 1'b0, ibAck)
        @(posedge mclk) errorSet <= 16'h0100;
        @(posedge mclk) errorSet <= 16'h0000;
        #1 `CHK("error set", 16'h0b5a, errorWord)
        pb(1'b1, UNPROT_ADDR, 16'h0005);
        `CHK("pb ack", 1'b1, pbAck)
        `CHK("unprot", 16'h0005, unprotectWord)
        pb(1'b0, UNPROT_ADDR, 16'h0000);
        `CHK("unprot read", 16'h0005, pbRdata)
        pb(1'b1, 16'h0e00, 16'h0000);
        `CHK("pb miss", 1'b0, pbAck)
        $display("test registers done");
        es(1'b0, ID_MEM_ADDR);
        `CHK("kind blank", 16'hf080, esRdata)
        es(1'b0, ID_PROG_ADDR);
        `CHK("prog", 16'h0040, esRdata)
        es(1'b1, ID_MAKER_ADDR);
        `CHK("write ack", 1'b1, esAck)
        es(1'b0, ID_MAKER_ADDR);
        `CHK("maker", {11'h155, 5'h03}, esRdata)
        es(1'b0, ID_PART_ADDR);
        `CHK("part", 16'h3c32, esRdata)
        `CHK("fetch ext", 1'b1, fetchEnable)
        @(posedge mclk) flashInitDone <= 1'b1;
        es(1'b0, ID_MEM_ADDR);
        `CHK("kind ready", 16'h3000 | 16'(512 / 4), esRdata)
        `CHK("valid", 1'b1, idValid)
        `CHK("poll bits", 2'b00, esRdata[15:14])
        $display("test external boot done");
        rst(1'b1, 5);
        `CHK("boot int", 1'b1, bootInternal)
        `CHK("fetch held", 1'b0, fetchEnable)
        @(posedge mclk) flashInitDone <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 `CHK("fetch go", 1'b1, fetchEnable)
        $display("test internal boot done");
        close_out();
    end
endmodule
